/* design/sdr_pkg.sv */
// constants, types and helper functions for the sdram access core
// Function
// [RULE1] row must be activated before read or write
// [RULE2] access waits activate-to-access time after activate
// [RULE3] same-bank activates need precharge and row-cycle spacing
// [RULE4] different-bank activates need bank-to-bank spacing
// [RULE5] read auto-precharge closes row after burst
// [RULE6] first read word after cas latency
// [RULE7] outputs float after burst; full page wraps
// [RULE8] chained read issued latency-minus-one before last
// [RULE9] read accepted on any cycle after read
// [RULE10] write may follow read data, gap advised
// [RULE11] mask raised three clocks before write
// [RULE12] registered write floats outputs if mask was high
// [RULE13] mask lowered before write, zero input latency
// [RULE14] precharge ends read, latency-minus-one early
// [RULE15] burst terminate ends read, latency-minus-one early
// [RULE16] write data taken from command edge onward
// [RULE17] new write truncates write, owns its data
// [RULE18] read truncating write drops remaining write data
// [RULE19] precharge waits write recovery after last data
// [RULE20] mask high around precharge truncating a write
// [RULE21] no same-bank command before precharge period ends
// [RULE22] terminate ignores its own write data
// [RULE23] read latency programmable as two or three
// [RULE24] burst lengths 1,2,4,8 and sequential full page
// [RULE25] controller tracks open rows and spacing counters
package sdr_pkg;

	// ----------------------------------------------------------------
	// geometry
	// ----------------------------------------------------------------
	localparam int DQ_W = 8;
	localparam int COL_W = 10;
	localparam int ROW_W = 13;
	localparam int BA_W = 2;
	localparam int BANKS = 4;
	localparam int ST_ROW_W = 2;
	localparam int ST_COL_W = 4;
	localparam int ST_AW = BA_W + ST_ROW_W + ST_COL_W;
	localparam int ST_DEPTH = 256;
	localparam int AP_BIT = 10;

	// ----------------------------------------------------------------
	// commands as {ras_n, cas_n, we_n}
	// ----------------------------------------------------------------
	localparam logic [2:0] CMD_ACT = 3'h3;
	localparam logic [2:0] CMD_READ = 3'h5;
	localparam logic [2:0] CMD_WRITE = 3'h4;
	localparam logic [2:0] CMD_PRE = 3'h2;
	localparam logic [2:0] CMD_BST = 3'h6;

	// ----------------------------------------------------------------
	// register port
	// ----------------------------------------------------------------
	localparam int RA_W = 8;
	localparam int RD_W = 32;
	localparam logic [RA_W-1:0] REG_CFG = 8'h00;
	localparam logic [RA_W-1:0] REG_STAT = 8'h04;
	localparam int CFG_W = 10;
	localparam int CFG_BL_LSB = 0;
	localparam int CFG_TYPE_BIT = 3;
	localparam int CFG_CL_LSB = 4;
	localparam int CFG_WSGL_BIT = 9;
	localparam logic [CFG_W-1:0] CFG_RST = 10'h032;
	localparam int STAT_OPEN_LSB = 0;
	localparam int STAT_RD_BIT = 4;
	localparam int STAT_WR_BIT = 5;
	localparam int STAT_BADWR_BIT = 8;
	localparam int STAT_CLOSED_BIT = 9;

	// ----------------------------------------------------------------
	// burst length and latency codes
	// ----------------------------------------------------------------
	localparam logic [2:0] BL_1 = 3'h0;
	localparam logic [2:0] BL_2 = 3'h1;
	localparam logic [2:0] BL_4 = 3'h2;
	localparam logic [2:0] BL_8 = 3'h3;
	localparam logic [2:0] BL_PAGE = 3'h7;
	localparam logic [2:0] CL_2 = 3'h2;

	typedef enum logic [1:0] {
		SDR_IDLE = 2'h0,
		SDR_READ = 2'h1,
		SDR_WRITE = 2'h3
	} sdr_eng_t;

	// ----------------------------------------------------------------
	// burst helpers
	// ----------------------------------------------------------------
	// column bits that wrap inside the burst block
	function automatic logic [COL_W-1:0] sdr_mask(input logic [2:0] bl);
		logic [COL_W-1:0] m;
		m = '0;
		unique case (bl)
			BL_1: m = 10'h000;
			BL_2: m = 10'h001;
			BL_4: m = 10'h003;
			BL_8: m = 10'h007;
			BL_PAGE: m = 10'h3FF;
			default: m = 10'h000;
		endcase
		return m;
	endfunction

	function automatic logic [COL_W-1:0] sdr_col(
		input logic [COL_W-1:0] start,
		input logic [COL_W-1:0] k,
		input logic [2:0] bl,
		input logic ilv
	);
		logic [COL_W-1:0] m;
		logic [COL_W-1:0] lo;
		m = sdr_mask(bl);
		// interleave exists only for fixed lengths
		lo = (ilv && bl != BL_PAGE) ? (start ^ k) : (start + k);
		return (start & ~m) | (lo & m);
	endfunction

	// storage holds a window of each bank; higher bits alias
	function automatic logic [ST_AW-1:0] sdr_idx(
		input logic [BA_W-1:0] b,
		input logic [ROW_W-1:0] r,
		input logic [COL_W-1:0] c
	);
		return {b, r[ST_ROW_W-1:0], c[ST_COL_W-1:0]};
	endfunction

endpackage

/* design/sdr_store.sv */
// flip-flop data array of the sdram core
`timescale 1ns/1ps
`default_nettype none
module sdr_store
	import sdr_pkg::*;
(
	input wire logic clk,
	input wire logic wr_en,
	input wire logic [ST_AW-1:0] wr_idx,
	input wire logic [DQ_W-1:0] wr_data,
	input wire logic [ST_AW-1:0] rd_idx,
	output logic [DQ_W-1:0] rd_data
);

	logic [DQ_W-1:0] mem_ff [ST_DEPTH];
	logic [DQ_W-1:0] nxt_mem [ST_DEPTH];

	// whole-array next value keeps the one-comb, one-ff style
	always_comb begin
		nxt_mem = mem_ff;
		if (wr_en) begin
			nxt_mem[wr_idx] = wr_data;
		end
	end

	// contents are not reset, like real cells
	always_ff @(posedge clk) begin
		mem_ff <= nxt_mem;
	end

	assign rd_data = mem_ff[rd_idx];

endmodule
`default_nettype wire

/* design/sdr_core.sv */
// sdram row activation, read and write burst engine
`timescale 1ns/1ps
`default_nettype none
module sdr_core
	import sdr_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [BA_W-1:0] ba,
	input wire logic [ROW_W-1:0] addr,
	input wire logic dqm,
	input wire logic [DQ_W-1:0] dq_in,
	output logic [DQ_W-1:0] dq_out,
	output logic dq_oe_n,
	input wire logic [RA_W-1:0] reg_addr,
	input wire logic [RD_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [RD_W-1:0] reg_rdata
);

	// ----------------------------------------------------------------
	// command decode
	// ----------------------------------------------------------------
	logic [2:0] cmd;
	logic is_act;
	logic is_rd;
	logic is_wr;
	logic is_pre;
	logic is_bst;
	logic bank_ok;
	logic rd_go;
	logic wr_go;
	logic wr_bad;
	logic pre_hit;
	logic cont;
	logic last;
	logic eng_end;
	logic [COL_W-1:0] cur_col;
	logic [ST_AW-1:0] cur_idx;
	logic [2:0] wbl;
	logic cl2;
	logic ilv;

	sdr_eng_t eng_ff, nxt_eng;
	logic [BA_W-1:0] ebank_ff, nxt_ebank;
	logic [COL_W-1:0] estart_ff, nxt_estart;
	logic [COL_W-1:0] ek_ff, nxt_ek;
	logic [2:0] ebl_ff, nxt_ebl;
	logic eap_ff, nxt_eap;

	logic [BANKS-1:0] open_ff, nxt_open;
	logic [ROW_W-1:0] row_ff [BANKS];
	logic [ROW_W-1:0] nxt_row [BANKS];

	logic p1_val_ff, nxt_p1_val;
	logic [DQ_W-1:0] p1_dat_ff, nxt_p1_dat;
	logic dqm_d_ff, nxt_dqm_d;
	logic oe_ff, nxt_oe;
	logic [DQ_W-1:0] dq_out_ff, nxt_dq_out;

	logic [CFG_W-1:0] cfg_ff, nxt_cfg;
	logic bad_wr_ff, nxt_bad_wr;
	logic closed_ff, nxt_closed;
	logic [RD_W-1:0] rdata_ff, nxt_rdata;

	logic st_we;
	logic [ST_AW-1:0] st_widx;
	logic [DQ_W-1:0] st_rdata;

	assign cmd = {ras_n, cas_n, we_n};
	assign is_act = !cs_n && cmd == CMD_ACT;
	assign is_rd = !cs_n && cmd == CMD_READ;
	assign is_wr = !cs_n && cmd == CMD_WRITE;
	assign is_pre = !cs_n && cmd == CMD_PRE;
	assign is_bst = !cs_n && cmd == CMD_BST;

	assign cl2 = cfg_ff[CFG_CL_LSB +: 3] == CL_2; // RULE23
	assign ilv = cfg_ff[CFG_TYPE_BIT];
	assign wbl = cfg_ff[CFG_WSGL_BIT] ? BL_1 : cfg_ff[CFG_BL_LSB +: 3];

	// accesses to an idle bank are dropped and flagged
	assign bank_ok = open_ff[ba]; // RULE1
	assign rd_go = is_rd && bank_ok; // RULE9
	// write while read data may still drive, with mask low before it
	assign wr_bad = (oe_ff || p1_val_ff || eng_ff == SDR_READ)
		&& !dqm_d_ff; // RULE12
	assign wr_go = is_wr && bank_ok && !wr_bad; // RULE17
	assign pre_hit = is_pre && (addr[AP_BIT] || ba == ebank_ff);

	// ----------------------------------------------------------------
	// burst engine
	// ----------------------------------------------------------------
	assign cur_col = sdr_col(estart_ff, ek_ff, ebl_ff, ilv); // RULE24
	assign cur_idx = sdr_idx(ebank_ff, row_ff[ebank_ff], cur_col);
	// full page never ends by count; the column simply wraps
	assign last = ebl_ff != BL_PAGE && ek_ff == sdr_mask(ebl_ff); // RULE7
	// terminate, a precharge of its bank or a new access stops the running burst
	assign cont = eng_ff != SDR_IDLE && !rd_go && !wr_go && !is_bst
		&& !pre_hit; // RULE15 RULE14
	assign eng_end = cont && last;

	always_comb begin
		nxt_eng = eng_ff;
		nxt_ebank = ebank_ff;
		nxt_estart = estart_ff;
		nxt_ek = ek_ff;
		nxt_ebl = ebl_ff;
		nxt_eap = eap_ff;
		if (rd_go) begin
			nxt_eng = SDR_READ;
			nxt_ebank = ba;
			nxt_estart = addr[COL_W-1:0];
			nxt_ek = '0;
			nxt_ebl = cfg_ff[CFG_BL_LSB +: 3];
			nxt_eap = addr[AP_BIT]; // RULE5
		end else if (wr_go) begin
			// word zero is stored on the command edge itself
			nxt_ebank = ba;
			nxt_estart = addr[COL_W-1:0];
			nxt_ek = COL_W'(1);
			nxt_ebl = wbl;
			nxt_eap = addr[AP_BIT];
			nxt_eng = (sdr_mask(wbl) == '0) ? SDR_IDLE : SDR_WRITE;
		end else if (!cont) begin
			nxt_eng = SDR_IDLE;
		end else if (last) begin
			nxt_eng = SDR_IDLE;
		end else begin
			nxt_ek = ek_ff + COL_W'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			eng_ff <= SDR_IDLE;
			ebank_ff <= '0;
			estart_ff <= '0;
			ek_ff <= '0;
			ebl_ff <= BL_1;
			eap_ff <= 1'b0;
		end else begin
			eng_ff <= nxt_eng;
			ebank_ff <= nxt_ebank;
			estart_ff <= nxt_estart;
			ek_ff <= nxt_ek;
			ebl_ff <= nxt_ebl;
			eap_ff <= nxt_eap;
		end
	end

	// ----------------------------------------------------------------
	// bank and row state
	// ----------------------------------------------------------------
	always_comb begin
		nxt_open = open_ff;
		nxt_row = row_ff;
		if (eng_end && eap_ff) begin
			nxt_open[ebank_ff] = 1'b0; // RULE5
		end
		if (wr_go && sdr_mask(wbl) == '0 && addr[AP_BIT]) begin
			nxt_open[ba] = 1'b0;
		end
		if (is_act) begin
			nxt_open[ba] = 1'b1;
			nxt_row[ba] = addr;
		end
		if (is_pre) begin
			if (addr[AP_BIT]) begin
				nxt_open = '0;
			end else begin
				nxt_open[ba] = 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			open_ff <= '0;
			for (int i = 0; i < BANKS; i++) begin
				row_ff[i] <= '0;
			end
		end else begin
			open_ff <= nxt_open;
			row_ff <= nxt_row;
		end
	end

	// ----------------------------------------------------------------
	// write path into storage
	// ----------------------------------------------------------------
	// a read, terminate or precharge of the burst bank on this edge drops the input word
	always_comb begin
		st_we = 1'b0;
		st_widx = cur_idx;
		if (wr_go) begin
			st_we = !dqm; // RULE16 RULE17
			st_widx = sdr_idx(ba, row_ff[ba], addr[COL_W-1:0]);
		end else if (eng_ff == SDR_WRITE && cont) begin
			st_we = !dqm; // RULE18 RULE22 RULE20
		end
	end

	sdr_store u_store (
		.clk(clk),
		.wr_en(st_we),
		.wr_idx(st_widx),
		.wr_data(dq_in),
		.rd_idx(cur_idx),
		.rd_data(st_rdata)
	);

	// ----------------------------------------------------------------
	// read data pipeline and output drive
	// ----------------------------------------------------------------
	// the fetched word is kept even when a read, terminate or precharge ends the burst on this edge,
	// so truncation lands exactly latency-minus-one later
	always_comb begin
		nxt_p1_val = eng_ff == SDR_READ && !is_wr; // RULE8
		nxt_p1_dat = st_rdata;
		nxt_dqm_d = dqm;
		nxt_dq_out = dq_out_ff;
		if (cl2) begin
			nxt_oe = nxt_p1_val; // RULE6
			if (nxt_p1_val) begin
				nxt_dq_out = st_rdata;
			end
		end else begin
			nxt_oe = p1_val_ff && !is_wr; // RULE6
			if (p1_val_ff) begin
				nxt_dq_out = p1_dat_ff;
			end
		end
		// mask sampled one edge earlier gives two clocks of latency
		if (dqm_d_ff) begin
			nxt_oe = 1'b0; // RULE11
		end
		// nothing valid leaves the pins floating
		if (is_wr) begin
			nxt_oe = 1'b0; // RULE12 RULE7
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			p1_val_ff <= 1'b0;
			p1_dat_ff <= '0;
			dqm_d_ff <= 1'b1;
			oe_ff <= 1'b0;
			dq_out_ff <= '0;
		end else begin
			p1_val_ff <= nxt_p1_val;
			p1_dat_ff <= nxt_p1_dat;
			dqm_d_ff <= nxt_dqm_d;
			oe_ff <= nxt_oe;
			dq_out_ff <= nxt_dq_out;
		end
	end

	assign dq_out = dq_out_ff;
	assign dq_oe_n = !oe_ff;

	// ----------------------------------------------------------------
	// register port
	// ----------------------------------------------------------------
	always_comb begin
		nxt_cfg = cfg_ff;
		nxt_bad_wr = bad_wr_ff;
		nxt_closed = closed_ff;
		nxt_rdata = '0;
		if (reg_wr && reg_addr == REG_CFG) begin
			nxt_cfg = reg_wdata[CFG_W-1:0];
		end
		if (reg_wr && reg_addr == REG_STAT) begin
			if (reg_wdata[STAT_BADWR_BIT]) begin
				nxt_bad_wr = 1'b0;
			end
			if (reg_wdata[STAT_CLOSED_BIT]) begin
				nxt_closed = 1'b0;
			end
		end
		// a new event beats a clear in the same cycle
		if (is_wr && bank_ok && wr_bad) begin
			nxt_bad_wr = 1'b1;
		end
		if ((is_rd || is_wr) && !bank_ok) begin
			nxt_closed = 1'b1;
		end
		if (reg_rd && reg_addr == REG_CFG) begin
			nxt_rdata[CFG_W-1:0] = cfg_ff;
		end
		if (reg_rd && reg_addr == REG_STAT) begin
			nxt_rdata[STAT_OPEN_LSB +: BANKS] = open_ff;
			nxt_rdata[STAT_RD_BIT] = eng_ff == SDR_READ;
			nxt_rdata[STAT_WR_BIT] = eng_ff == SDR_WRITE;
			nxt_rdata[STAT_BADWR_BIT] = bad_wr_ff;
			nxt_rdata[STAT_CLOSED_BIT] = closed_ff;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cfg_ff <= CFG_RST;
			bad_wr_ff <= 1'b0;
			closed_ff <= 1'b0;
			rdata_ff <= '0;
		end else begin
			cfg_ff <= nxt_cfg;
			bad_wr_ff <= nxt_bad_wr;
			closed_ff <= nxt_closed;
			rdata_ff <= nxt_rdata;
		end
	end

	assign reg_rdata = rdata_ff;

endmodule
`default_nettype wire

/* testbench/sdr_core_asserts.sv */
// port assertions for the sdram access core
`timescale 1ns/1ps
`default_nettype none
module sdr_core_chk
	import sdr_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [BA_W-1:0] ba,
	input wire logic [ROW_W-1:0] addr,
	input wire logic dqm,
	input wire logic [DQ_W-1:0] dq_in,
	input wire logic [DQ_W-1:0] dq_out,
	input wire logic dq_oe_n,
	input wire logic [RA_W-1:0] reg_addr,
	input wire logic [RD_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [RD_W-1:0] reg_rdata
);
	logic rd_c, wr_c, cfg_w, cl3_ff, nxt_cl3, page_ff, nxt_page;
	logic [3:0] age_ff, nxt_age;
	assign rd_c = !cs_n && {ras_n, cas_n, we_n} == CMD_READ;
	assign wr_c = !cs_n && {ras_n, cas_n, we_n} == CMD_WRITE;
	assign cfg_w = reg_wr && reg_addr == REG_CFG;
	// shadow of latency and page mode; age saturates so it never wraps
	always_comb begin
		nxt_cl3 = cfg_w ? reg_wdata[6:4] != CL_2 : cl3_ff;
		nxt_page = cfg_w ? reg_wdata[2:0] == BL_PAGE : page_ff;
		nxt_age = rd_c ? 4'h1 : age_ff + {3'h0, age_ff != 4'hF};
	end
	always_ff @(posedge clk) begin
		{cl3_ff, page_ff, age_ff} <= rst ? 6'h2F
			: {nxt_cl3, nxt_page, nxt_age};
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	property p_rst_idle;
		disable iff (1'b0) rst |=> dq_oe_n && dq_out == '0 && reg_rdata == '0;
	endproperty
	a_rst_idle: assert property (p_rst_idle) else $error("not idle in reset");
	property p_rdata_idle;
		!$past(reg_rd) |-> reg_rdata == '0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("stray rdata");
	property p_unmapped;
		reg_rd && reg_addr != REG_CFG && reg_addr != REG_STAT
			|=> reg_rdata == '0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read");
	property p_cfg_rb;
		cfg_w ##2 (reg_rd && reg_addr == REG_CFG)
			|=> reg_rdata[CFG_W-1:0] == $past(reg_wdata[CFG_W-1:0], 3);
	endproperty
	a_cfg_rb: assert property (p_cfg_rb) else $error("cfg readback");
	property p_cl2_first;
		rd_c && !cl3_ff && !dqm ##1 !wr_c |=> !dq_oe_n;
	endproperty
	a_cl2_first: assert property (p_cl2_first) else $error("cl2 late");
	property p_cl3_first;
		rd_c && cl3_ff && !dqm ##1 !wr_c ##1 !wr_c |=> !dq_oe_n;
	endproperty
	a_cl3_first: assert property (p_cl3_first) else $error("cl3 late");
	property p_cl3_early;
		rd_c && cl3_ff && age_ff == 4'hF |=> dq_oe_n [*2];
	endproperty
	a_cl3_early: assert property (p_cl3_early) else $error("cl3 early");
	property p_rd_b2b;
		rd_c && !cl3_ff && !dqm ##1 rd_c && !dqm ##1 !wr_c |-> !dq_oe_n [*2];
	endproperty
	a_rd_b2b: assert property (p_rd_b2b) else $error("read gap");
	property p_wr_float;
		wr_c |=> dq_oe_n;
	endproperty
	a_wr_float: assert property (p_wr_float) else $error("drive on write");
	property p_float;
		age_ff == 4'hC && !page_ff |-> dq_oe_n;
	endproperty
	a_float: assert property (p_float) else $error("no float");
endmodule
`default_nettype wire

/* testbench/sdr_ctl_model.sv */
// memory controller model driving the sdram pins
`timescale 1ns/1ps
`default_nettype none
module sdr_ctl_model
	import sdr_pkg::*;
#(
	parameter int T_RCD = 3,
	parameter int T_RC = 12,
	parameter int T_RRD = 2,
	parameter int T_RP = 3
)
(
	input wire logic clk,
	output logic cs_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic [BA_W-1:0] ba,
	output logic [ROW_W-1:0] addr,
	output logic dqm,
	output logic [DQ_W-1:0] dq_in
);
	int cyc = 0;
	int last_act = -100;
	int act_at [BANKS] = '{default: -100};
	int pre_at [BANKS] = '{default: -100};
	initial begin
		{cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq_in} = '1;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
	end
	task automatic cmd(input logic [2:0] c, input logic [BA_W-1:0] b,
		input logic [ROW_W-1:0] a, input logic [DQ_W-1:0] d, input logic m);
		@(posedge clk);
		// hold off early commands rather than send them; stop has no bank
		while (c != CMD_BST && (cyc - pre_at[b] < T_RP
			|| (c == CMD_ACT ? cyc - act_at[b] < T_RC
			|| cyc - last_act < T_RRD
			: cyc - act_at[b] < T_RCD))) begin
			{cs_n, dq_in} <= {1'b1, ~dq_in};
			@(posedge clk);
		end
		{cs_n, ras_n, cas_n, we_n, ba, addr, dq_in, dqm}
			<= {1'b0, c, b, a, d, m};
		if (c == CMD_ACT) begin
			{act_at[b], last_act} = {cyc, cyc};
		end
		if (c == CMD_PRE) begin
			pre_at[b] = cyc;
		end
	endtask
	task automatic dat(input logic [DQ_W-1:0] d, input logic m);
		@(posedge clk);
		{cs_n, dq_in, dqm} <= {1'b1, d, m};
	endtask
	// released lines keep moving so a stale word never looks valid
	task automatic idle();
		@(posedge clk);
		{cs_n, dq_in, dqm} <= {1'b1, ~dq_in, 1'b0};
	endtask
endmodule
`default_nettype wire

/* testbench/sdram_row_and_burst_access_tb.sv */
// self-checking bench for the sdram access core
`timescale 1ns/1ps
`default_nettype none
module sdram_row_and_burst_access_tb
	import sdr_pkg::*;
;
	logic clk, rst, cs_n, ras_n, cas_n, we_n, dqm, dq_oe_n, reg_wr, reg_rd;
	logic [BA_W-1:0] ba;
	logic [ROW_W-1:0] addr;
	logic [DQ_W-1:0] dq_in, dq_out;
	logic [RA_W-1:0] reg_addr;
	logic [RD_W-1:0] reg_wdata, reg_rdata, rv;
	int error_cnt = 0;
	int check_count = 0;
`define CHK(g, e, s) begin check_count++; if ((g) !== (e)) begin \
	error_cnt++; $display("CHECK FAILED %0t %s", $time, s); end end
	sdr_core dut (.clk(clk), .rst(rst), .cs_n(cs_n), .ras_n(ras_n),
		.cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dqm(dqm),
		.dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata));
	sdr_ctl_model ctl (.clk(clk), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
		.we_n(we_n), .ba(ba), .addr(addr), .dqm(dqm), .dq_in(dq_in));
	task automatic wreg(input logic [RA_W-1:0] a, input logic [RD_W-1:0] d);
		@(posedge clk);
		{reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rreg(input logic [RA_W-1:0] a);
		@(posedge clk);
		{reg_addr, reg_rd} <= {a, 1'b1};
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata;
	endtask
	task automatic wburst(input logic [9:0] c, input logic [7:0] d);
		ctl.cmd(CMD_WRITE, 2'h0, {3'h0, c}, d, 1'b0);
		for (int k = 1; k < 4; k++) ctl.dat(d + 8'(k), 1'b0);
	endtask
	task automatic chk_out(input int dly, input logic [7:0] e [$]);
		repeat (dly) @(posedge clk);
		foreach (e[k]) begin
			#1 `CHK(dq_oe_n, 1'b0, "not driven")
			`CHK(dq_out, e[k], "read data")
			@(posedge clk);
		end
		#1 `CHK(dq_oe_n, 1'b1, "not floated")
	endtask
	task automatic results();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		#20us;
		error_cnt++;
		$display("CHECK FAILED %0t watchdog", $time);
		results();
	end
	initial begin
		{rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'h4, 40'h0};
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rreg(REG_CFG);
		`CHK(rv[9:0], CFG_RST, "cfg reset")
		rreg(8'h08);
		`CHK(rv, 32'h0, "unmapped")
		ctl.cmd(CMD_ACT, 2'h0, 13'h0, 8'h0, 1'b0);
		for (int i = 0; i < 16; i += 4) wburst(10'(i), 8'(i));
		rreg(REG_STAT);
		`CHK(rv[3:0], 4'h1, "bank open")
		ctl.cmd(CMD_READ, 2'h0, 13'h2, 8'h0, 1'b0);
		ctl.idle();
		chk_out(2, {8'h02, 8'h03, 8'h00, 8'h01});
		// overwrite one word, then truncate that write with another
		ctl.cmd(CMD_WRITE, 2'h0, 13'h0, 8'h80, 1'b0);
		wburst(10'h8, 8'h90);
		wreg(REG_CFG, 32'h22);
		rreg(REG_CFG);
		`CHK(rv[9:0], 10'h022, "cfg write")
		ctl.cmd(CMD_READ, 2'h0, 13'h0, 8'h0, 1'b0);
		ctl.cmd(CMD_READ, 2'h0, 13'h8, 8'h0, 1'b0);
		ctl.idle();
		chk_out(0, {8'h80, 8'h90, 8'h91, 8'h92, 8'h93});
		ctl.cmd(CMD_WRITE, 2'h0, 13'h4, 8'hA4, 1'b0);
		ctl.cmd(CMD_READ, 2'h0, 13'h4, 8'hA5, 1'b0);
		ctl.idle();
		chk_out(1, {8'hA4, 8'h05, 8'h06, 8'h07});
		ctl.cmd(CMD_WRITE, 2'h0, 13'hC, 8'hC0, 1'b0);
		ctl.cmd(CMD_BST, 2'h0, 13'h0, 8'hC1, 1'b0);
		ctl.cmd(CMD_READ, 2'h0, 13'hC, 8'h0, 1'b0);
		ctl.idle();
		chk_out(1, {8'hC0, 8'h0D, 8'h0E, 8'h0F});
		// write into pending read data, unmasked then masked
		ctl.cmd(CMD_READ, 2'h0, 13'h0, 8'h0, 1'b0);
		ctl.cmd(CMD_WRITE, 2'h0, 13'h0, 8'h66, 1'b0);
		ctl.idle();
		rreg(REG_STAT);
		`CHK(rv[STAT_BADWR_BIT], 1'b1, "bad write flag")
		wreg(REG_STAT, 32'h100);
		repeat (2) ctl.dat(8'h0, 1'b1);
		ctl.cmd(CMD_READ, 2'h0, 13'h0, 8'h0, 1'b1);
		wburst(10'h0, 8'h55);
		rreg(REG_STAT);
		`CHK(rv[STAT_BADWR_BIT], 1'b0, "good write flag")
		wreg(REG_CFG, 32'h2B);
		ctl.cmd(CMD_READ, 2'h0, 13'h9, 8'h0, 1'b0);
		ctl.idle();
		chk_out(1, {8'h91, 8'h90, 8'h93, 8'h92,
			8'h0D, 8'hC0, 8'h0F, 8'h0E});
		wreg(REG_CFG, 32'h27);
		ctl.cmd(CMD_READ, 2'h0, 13'h3FE, 8'h0, 1'b0);
		fork
			chk_out(2, {8'h0E, 8'h0F, 8'h55, 8'h56});
			begin
				repeat (3) ctl.idle();
				ctl.cmd(CMD_BST, 2'h0, 13'h0, 8'h0, 1'b0);
				ctl.idle();
			end
		join
		wreg(REG_CFG, 32'h22);
		ctl.cmd(CMD_READ, 2'h0, 13'h400, 8'h0, 1'b0);
		ctl.idle();
		chk_out(1, {8'h55, 8'h56, 8'h57, 8'h58});
		rreg(REG_STAT);
		`CHK(rv[3:0], 4'h0, "auto close")
		ctl.cmd(CMD_READ, 2'h0, 13'h0, 8'h0, 1'b1);
		ctl.idle();
		rreg(REG_STAT);
		`CHK(rv[STAT_CLOSED_BIT], 1'b1, "closed bank")
		// two banks open; a write and a read are each cut by precharge
		ctl.cmd(CMD_ACT, 2'h1, 13'h0, 8'h0, 1'b0);
		ctl.cmd(CMD_ACT, 2'h0, 13'h0, 8'h0, 1'b0);
		ctl.cmd(CMD_WRITE, 2'h0, 13'h0, 8'h71, 1'b0);
		ctl.dat(8'h72, 1'b0);
		ctl.dat(8'h73, 1'b1);
		ctl.cmd(CMD_PRE, 2'h0, 13'h0, 8'h74, 1'b1);
		ctl.cmd(CMD_ACT, 2'h0, 13'h0, 8'h0, 1'b0);
		ctl.cmd(CMD_READ, 2'h0, 13'h0, 8'h0, 1'b0);
		ctl.idle();
		chk_out(1, {8'h71, 8'h72, 8'h57, 8'h58});
		ctl.cmd(CMD_READ, 2'h0, 13'h0, 8'h0, 1'b0);
		ctl.cmd(CMD_PRE, 2'h0, 13'h0, 8'h0, 1'b0);
		ctl.idle();
		chk_out(0, {8'h71});
		rreg(REG_STAT);
		`CHK(rv[3:0], 4'h2, "bank precharged")
		ctl.cmd(CMD_PRE, 2'h1, 13'h400, 8'h0, 1'b0);
		ctl.idle();
		rreg(REG_STAT);
		`CHK(rv[3:0], 4'h0, "all precharged")
		// a second reset must bring the configuration back
		@(posedge clk) rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rreg(REG_CFG);
		`CHK(rv[9:0], CFG_RST, "cfg after reset")
		results();
	end
endmodule
bind sdr_core sdr_core_chk u_chk (.clk(clk), .rst(rst), .cs_n(cs_n),
	.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr),
	.dqm(dqm), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata));
`default_nettype wire
